// file: qit_timer.v
// Quad 8-bit interval timer with shared interrupt, step table and LED toggles
//
// Functional notes
// - Four independent 8-bit channel counters each set their own match flag when the count equals their compare value.
// - One shared timer interrupt covers matches of all channels; software reads the flags to find the source.
// - Each channel holds a writable 8-bit compare value, reset to 3F, 7F, BF and FF for channels 0 to 3.
// - Each channel counts the base clock divided by 1, 2, 4, 8, 16, 32, 64 or 128, chosen per channel.
// - In step k channel n divides by 2 to the power (2n + k - 1) mod 8, and each press advances k, wrapping 8 to 1.
// - A falling edge on the switch input counts one press and moves all channels to the next divider step.
// - Each channel counts its matches and toggles its LED when the count reaches 2000.
// - The shared interrupt leaves the block only while enabled, yet match flags are recorded regardless.
// - The shared interrupt wakes the processor from its wait state; match counts update on every match, waiting or not.
`include "qit_defs.vh"

module qit_timer #(
  parameter CHANNELS        = `QIT_CHANNELS,
  parameter LED_MATCH_COUNT = `QIT_LED_MATCH_COUNT
) (
  input  wire                            sys_clk,
  input  wire                            sys_rst,
  input  wire                            timerRun,
  input  wire [CHANNELS-1:0]             compareWrite,
  input  wire [`QIT_CNT_WIDTH-1:0]       compareData,
  input  wire                            sharedIrqEnable,
  input  wire [CHANNELS-1:0]             matchFlagClear,
  input  wire                            switchIn,
  input  wire                            waitEnter,
  output reg  [CHANNELS-1:0]             matchFlag,
  output reg                             sharedTimerIrq,
  output reg                             switchEdgeIrq,
  output reg  [CHANNELS-1:0]             ledOut,
  output reg                             waitActive,
  output reg  [`QIT_DIVSEL_WIDTH-1:0]    stepIndex,
  output reg  [`QIT_PRESS_CNT_WIDTH-1:0] pressCount
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Divider exponent for channel n at zero-based step s
  function [`QIT_DIVSEL_WIDTH-1:0] divForChannel;
    input [`QIT_DIVSEL_WIDTH-1:0] chanIdx;
    input [`QIT_DIVSEL_WIDTH-1:0] stepIdx;
    begin
      divForChannel = (chanIdx << 1) + stepIdx;
    end
  endfunction

  function [`QIT_CNT_WIDTH-1:0] compareResetValue;
    input integer chanIdx;
    begin
      case (chanIdx % 4)
        0:       compareResetValue = `QIT_CMP_CH0_RESET;
        1:       compareResetValue = `QIT_CMP_CH1_RESET;
        2:       compareResetValue = `QIT_CMP_CH2_RESET;
        default: compareResetValue = `QIT_CMP_CH3_RESET;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [`QIT_CNT_WIDTH-1:0]       compareReg [0:CHANNELS-1];
  reg  [`QIT_MATCH_CNT_WIDTH-1:0] matchCountReg [0:CHANNELS-1];
  reg                             switchPrevReg;
  reg  [`QIT_DIVSEL_WIDTH-1:0]    stepReg;
  wire [CHANNELS-1:0]             matchPulse;
  wire [CHANNELS-1:0]             flagNext;
  wire                            switchFall;
  wire                            irqNext;

  // ----------------------------------------------------------------
  // Switch edge and step table
  // ----------------------------------------------------------------
  assign switchFall = switchPrevReg && !switchIn;

  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      switchPrevReg <= 1'b1;
      stepReg       <= {`QIT_DIVSEL_WIDTH{1'b0}};
      stepIndex     <= {`QIT_DIVSEL_WIDTH{1'b0}};
      pressCount    <= {`QIT_PRESS_CNT_WIDTH{1'b0}};
      switchEdgeIrq <= 1'b0;
    end
    else
    begin
      switchPrevReg <= switchIn;
      switchEdgeIrq <= switchFall;
      if (switchFall)
      begin
        // Three-bit step wraps from step 8 to step 1 by itself
        stepReg    <= stepReg + 1'b1;
        stepIndex  <= stepReg + 1'b1;
        pressCount <= pressCount + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1)
    begin : gChan
      localparam [`QIT_DIVSEL_WIDTH-1:0] CHAN_IDX = ch;

      always @(posedge sys_clk)
      begin
        if (sys_rst)
          compareReg[ch] <= compareResetValue(ch);
        else if (compareWrite[ch])
          compareReg[ch] <= compareData;
      end

      qit_channel #(
        .CNT_WIDTH (`QIT_CNT_WIDTH)
      ) uChannel (
        .sys_clk      (sys_clk),
        .sys_rst      (sys_rst),
        .countRun     (timerRun),
        .divSel       (divForChannel(CHAN_IDX, stepReg)),
        .compareValue (compareReg[ch]),
        .matchPulse   (matchPulse[ch])
      );

      // Set beats clear so a match landing on a clear is not lost
      assign flagNext[ch] = matchPulse[ch] || (matchFlag[ch] && !matchFlagClear[ch]);

      always @(posedge sys_clk)
      begin
        if (sys_rst)
        begin
          matchFlag[ch]     <= 1'b0;
          matchCountReg[ch] <= {`QIT_MATCH_CNT_WIDTH{1'b0}};
          ledOut[ch]        <= 1'b0;
        end
        else
        begin
          matchFlag[ch] <= flagNext[ch];
          if (matchPulse[ch])
          begin
            if (matchCountReg[ch] == LED_MATCH_COUNT - 1)
            begin
              matchCountReg[ch] <= {`QIT_MATCH_CNT_WIDTH{1'b0}};
              ledOut[ch]        <= !ledOut[ch];
            end
            else
              matchCountReg[ch] <= matchCountReg[ch] + 1'b1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Shared interrupt and wait state
  // ----------------------------------------------------------------
  // Any set flag keeps the line up; gating only hides it, flags still record
  assign irqNext = sharedIrqEnable && (|flagNext);

  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sharedTimerIrq <= 1'b0;
      waitActive     <= 1'b0;
    end
    else
    begin
      sharedTimerIrq <= irqNext;
      if (irqNext)
        waitActive <= 1'b0;
      else if (waitEnter)
        waitActive <= 1'b1;
    end
  end

endmodule // qit_timer

// file: qit_defs.vh
// Constants for the quad 8-bit interval timer
`ifndef QIT_DEFS_VH
`define QIT_DEFS_VH

`define QIT_CHANNELS         4
`define QIT_CNT_WIDTH        8
`define QIT_DIVSEL_WIDTH     3
`define QIT_STEP_COUNT       8
`define QIT_PRESCALE_WIDTH   7
`define QIT_CMP_CH0_RESET    8'h3F
`define QIT_CMP_CH1_RESET    8'h7F
`define QIT_CMP_CH2_RESET    8'hBF
`define QIT_CMP_CH3_RESET    8'hFF
`define QIT_LED_MATCH_COUNT  2000
`define QIT_MATCH_CNT_WIDTH  11
`define QIT_PRESS_CNT_WIDTH  16

`endif

// file: qit_channel.v
// One 8-bit interval timer channel with its own clock divider
`include "qit_defs.vh"

module qit_channel #(
  parameter CNT_WIDTH = `QIT_CNT_WIDTH
) (
  input  wire                         sys_clk,
  input  wire                         sys_rst,
  input  wire                         countRun,
  input  wire [`QIT_DIVSEL_WIDTH-1:0] divSel,
  input  wire [CNT_WIDTH-1:0]         compareValue,
  output reg                          matchPulse
);

  reg  [`QIT_PRESCALE_WIDTH-1:0] prescaleReg;
  reg  [CNT_WIDTH-1:0]           countReg;
  wire [`QIT_PRESCALE_WIDTH-1:0] divMask;
  wire                           countTick;
  wire                           countEqual;

  // ----------------------------------------------------------------
  // Divider: a tick every 2^divSel base clocks
  // ----------------------------------------------------------------
  assign divMask    = ~({`QIT_PRESCALE_WIDTH{1'b1}} << divSel);
  assign countTick  = countRun && ((prescaleReg & divMask) == divMask);
  assign countEqual = (countReg == compareValue);

  always @(posedge sys_clk)
  begin
    if (sys_rst || !countRun)
      prescaleReg <= {`QIT_PRESCALE_WIDTH{1'b0}};
    else
      prescaleReg <= prescaleReg + 1'b1;
  end

  // ----------------------------------------------------------------
  // Counter: period of compare value plus one ticks
  // ----------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (sys_rst || !countRun)
    begin
      countReg   <= {CNT_WIDTH{1'b0}};
      matchPulse <= 1'b0;
    end
    else
    begin
      matchPulse <= countTick && countEqual;
      if (countTick)
      begin
        if (countEqual)
          countReg <= {CNT_WIDTH{1'b0}};
        else
          countReg <= countReg + 1'b1;
      end
    end
  end

endmodule // qit_channel

// file: qit_timer_props.sv
// Port checker of the quad interval timer
module qit_timer_props #(
  parameter CHANNELS = 4
) (
  input wire                sys_clk,
  input wire                sys_rst,
  input wire                timerRun,
  input wire                sharedIrqEnable,
  input wire [CHANNELS-1:0] matchFlagClear,
  input wire                switchIn,
  input wire                waitEnter,
  input wire [CHANNELS-1:0] matchFlag,
  input wire                sharedTimerIrq,
  input wire                switchEdgeIrq,
  input wire [CHANNELS-1:0] ledOut,
  input wire                waitActive,
  input wire [2:0]          stepIndex,
  input wire [15:0]         pressCount
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  a_flag_sticky: assert property (1 |=> &(matchFlag | ~$past(matchFlag & ~matchFlagClear)))
    else $error("match flag dropped without clear");
  a_irq_gate: assert property (sharedTimerIrq == ($past(sharedIrqEnable) && (|matchFlag)))
    else $error("shared interrupt wrong");
  a_press_pulse: assert property ($fell(switchIn) |=> switchEdgeIrq)
    else $error("press not seen");
  a_press_step: assert property (switchEdgeIrq |-> stepIndex == $past(stepIndex) + 3'h1)
    else $error("step not advanced");
  a_press_count: assert property (switchEdgeIrq |-> pressCount == $past(pressCount) + 16'h0001)
    else $error("press count not advanced");
  a_wait_enter: assert property (waitEnter |=> waitActive || sharedTimerIrq)
    else $error("wait not entered");
  a_wait_wake: assert property (sharedTimerIrq |-> !waitActive)
    else $error("interrupt left wait active");
  a_led_flag: assert property (((ledOut ^ $past(ledOut)) & ~matchFlag) == '0)
    else $error("led toggled without match");
  a_stop_quiet: assert property (!timerRun [*3] |=> (matchFlag & ~$past(matchFlag)) == '0)
    else $error("match while stopped");
endmodule // qit_timer_props

bind qit_timer qit_timer_props #(.CHANNELS(CHANNELS)) u_props (.sys_clk, .sys_rst, .timerRun, .sharedIrqEnable,
  .matchFlagClear, .switchIn, .waitEnter, .matchFlag, .sharedTimerIrq, .switchEdgeIrq, .ledOut, .waitActive,
  .stepIndex, .pressCount);

// file: qit_timer_tb.sv
// Self-checking bench of the quad interval timer
module qit_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        timerRun = 1'b0;
  logic        sharedIrqEnable = 1'b0;
  logic        switchIn = 1'b1;
  logic        waitEnter = 1'b0;
  logic [3:0]  compareWrite = 4'h0;
  logic [3:0]  matchFlagClear = 4'h0;
  logic [7:0]  compareData = 8'h00;
  logic [31:0] lfsr = 32'h266D;
  logic [7:0]  cmpv [4];
  wire  [3:0]  matchFlag;
  wire  [3:0]  ledOut;
  wire         sharedTimerIrq;
  wire         switchEdgeIrq;
  wire         waitActive;
  wire  [2:0]  stepIndex;
  wire  [15:0] pressCount;
  int          failCount = 0;
  int          checksDone = 0;
  int          cnt [4];
  int          t;
  always #2 sys_clk = ~sys_clk;
  qit_timer #(.LED_MATCH_COUNT(4)) u_dut (.sys_clk, .sys_rst, .timerRun, .compareWrite, .compareData,
    .sharedIrqEnable, .matchFlagClear, .switchIn, .waitEnter, .matchFlag, .sharedTimerIrq, .switchEdgeIrq,
    .ledOut, .waitActive, .stepIndex, .pressCount);
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic int per(input int n, input int s, input int c);
    return (c + 1) << ((2 * n + s) % 8);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input logic ok, input string msg);
    checksDone++;
    if (!ok)
    begin
      failCount++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic closeOut();
    $display("checks %0d, mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Clear first, so a stale sticky flag cannot shorten the gap
  task automatic gap(input int n, output int g);
    matchFlagClear[n] = 1'b1;
    cyc(1);
    matchFlagClear[n] = 1'b0;
    for (g = 1; matchFlag[n] !== 1'b1 && g < 2000; g++)
      cyc(1);
  endtask
  initial
  begin
    #400us;
    failCount++;
    $display("unexpected at %0t: watchdog", $time);
    closeOut();
  end
  initial
  begin
    cyc(12);
    sys_rst = 1'b0;
    chk({matchFlag, ledOut, sharedTimerIrq, switchEdgeIrq, waitActive, stepIndex, pressCount} === 30'h0, "reset");
    waitEnter = 1'b1;
    cyc(1);
    waitEnter = 1'b0;
    for (int n = 0; n < 4; n++)
    begin
      lfsr = nxt(lfsr);
      cmpv[n] = {6'h00, lfsr[1:0]} + 8'h01;
      compareWrite = 4'h1 << n;
      compareData = cmpv[n];
      cyc(1);
    end
    compareWrite = 4'h0;
    timerRun = 1'b1;
    cyc(20);
    chk(matchFlag[0] === 1'b1 && sharedTimerIrq === 1'b0 && waitActive === 1'b1, "masked");
    sharedIrqEnable = 1'b1;
    cyc(1);
    chk(sharedTimerIrq === 1'b1 && waitActive === 1'b0, "wake");
    for (int s = 0; s < 8; s++)
    begin
      chk(stepIndex === 3'(s) && pressCount === 16'(s), "step");
      for (int n = 0; n < 4; n++)
      begin
        gap(n, t);
        gap(n, t);
        chk(t == per(n, s, cmpv[n]), "period");
      end
      lfsr = nxt(lfsr);
      sharedIrqEnable = lfsr[0];
      switchIn = 1'b0;
      cyc(1);
      switchIn = 1'b1;
      cyc(2);
    end
    chk(stepIndex === 3'h0 && pressCount === 16'h0008, "wrap");
    matchFlagClear = 4'hF;
    timerRun = 1'b0;
    cyc(8);
    chk(matchFlag === 4'h0, "stopped");
    sys_rst = 1'b1;
    cyc(2);
    sys_rst = 1'b0;
    compareWrite = 4'hF;
    compareData = 8'h01;
    matchFlagClear = 4'hF;
    cyc(1);
    compareWrite = 4'h0;
    timerRun = 1'b1;
    repeat (1200)
    begin
      cyc(1);
      chk(sharedTimerIrq === (sharedIrqEnable & (|matchFlag)), "irq");
      for (int n = 0; n < 4; n++)
      begin
        cnt[n] += int'(matchFlag[n]);
        chk(ledOut[n] === 1'((cnt[n] / 4) % 2), "led");
      end
      lfsr = nxt(lfsr);
      sharedIrqEnable = lfsr[0];
    end
    closeOut();
  end
endmodule // qit_timer_tb
